// *** verilog/spe_consts.svh ***
// Constants of the serial EEPROM command block: opcodes, status layout, timing.
// Included by the package user files; holds definitions only.
`ifndef SPE_CONSTS_SVH
`define SPE_CONSTS_SVH

`define SPE_OP_READ 8'h03
`define SPE_OP_WRITE 8'h02
`define SPE_OP_LSET 8'h06
`define SPE_OP_LCLR 8'h04
`define SPE_OP_SREAD 8'h05
`define SPE_OP_SWRITE 8'h01

`define SPE_ST_PPE 7
`define SPE_ST_BPH 3
`define SPE_ST_BPL 2
`define SPE_ST_WEL 1
`define SPE_ST_BUSY 0
`define SPE_ST_RESET 8'h00

`define SPE_ADDR_LAST 4'hf
`define SPE_CLK_HZ 10000000
`define SPE_WR_TIME_US 5000
`define SPE_WR_CYCLES (`SPE_WR_TIME_US * (`SPE_CLK_HZ / 1000000))
`define SPE_PROG_DIV 8

`endif

// *** verilog/spe_pkg.sv ***
// Types shared by the serial EEPROM command block.
// Assumes the constants header is compiled alongside.
package spe_pkg;
  typedef enum logic [3:0] {
    P_CMD, P_ADDR, P_READ, P_WRITE, P_SREAD, P_SWRITE, P_LSET, P_LCLR, P_IGN
  } spe_phase_t;
endpackage

// *** verilog/spe_eeprom.sv ***
// Serial EEPROM command logic with its commit FIFO and storage arrays.
// Assumes all link pins are asynchronous to clk and far slower than it.
//
// Contract
// - Eight-bit opcode, input sampled on clock rise.
// - All fields shift most significant bit first.
// - First bit taken on first rise after select.
// - Hold pauses sequence; release resumes it unchanged.
// - Read: opcode, 16-bit address, data out.
// - Read pointer advances after each byte.
// - Read pointer wraps from top to zero.
// - Deselect ends read and stops output.
// - Latch set only on deselect after opcode.
// - Write: opcode, address, one to 64 bytes.
// - Write address wraps inside its page.
// - Write starts only on deselect after byte.
// - Busy refuses array reads, allows status reads.
// - Latch clears at reset, write end, success.
// - Read, write, latch-set opcode values fixed.
// - Latch-clear, status read/write opcodes fixed.
// - Status byte layout: enable, protect, latch, busy.
// - Busy reads one during write; read-only bits.
// - Latch opcodes work despite hardware protection.
// - Protect bits block none, quarter, half, all.
// - Low protect pin with enable blocks status writes.
// - Output changes after clock fall.
// - Write cycle starts at deselect, within five ms.
// - Hold tri-states output, ignores clock and data.
// - Array access during write is ignored.
`timescale 1ns/1ps
`include "spe_consts.svh"

module spe_fifo #(
  parameter int W = 14,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Fill side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rp_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    nxt = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_comb begin
    wp_d = push ? nxt(wp_q) : wp_q;
    rp_d = pop ? nxt(rp_q) : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end
endmodule

module spe_eeprom #(
  parameter int ADDR_W = 15,
  parameter int PAGE_W = 6,
  parameter int FIFO_DEPTH = 4,
  parameter int WR_CYCLES = `SPE_WR_CYCLES,
  parameter int PROG_DIV = `SPE_PROG_DIV
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Serial link from the host.
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  // Serial output pin.
  output logic so,
  output logic so_oe_n
);
  localparam int TW = $clog2(WR_CYCLES + 1);
  localparam int DW = $clog2(PROG_DIV + 1);
  localparam int FW = PAGE_W + 8;
  localparam int PAGE = 1 << PAGE_W;

  logic [7:0] mem [0:(1<<ADDR_W)-1];
  logic [7:0] pbuf [0:PAGE-1];

  // Pin synchronisers; only bit 0 is the raw capture.
  logic [2:0] sck_q, cs_q;
  logic [1:0] si_q, hold_q, wp_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sck_q <= 3'h0;
      cs_q <= 3'h7;
      si_q <= 2'h0;
      hold_q <= 2'h3;
      wp_q <= 2'h3;
    end else begin
      sck_q <= {sck_q[1:0], sck};
      cs_q <= {cs_q[1:0], cs_n};
      si_q <= {si_q[0], si};
      hold_q <= {hold_q[0], hold_n};
      wp_q <= {wp_q[0], wp_n};
    end
  end

  logic sck_rise, sck_fall, cs_low, cs_rise, active, si_s, hw_prot;
  assign sck_rise = sck_q[1] & ~sck_q[2];
  assign sck_fall = ~sck_q[1] & sck_q[2];
  assign cs_low = ~cs_q[1];
  assign cs_rise = cs_q[1] & ~cs_q[2];
  // Edges are ignored while held, so counters freeze and resume in place.
  assign active = cs_low & hold_q[1];
  assign si_s = si_q[1];

  spe_pkg::spe_phase_t phase_q, phase_d;
  logic [3:0] cnt_q, cnt_d;
  logic [15:0] sh_q, sh_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [7:0] dout_q, dout_d;
  logic is_wr_q, is_wr_d, got_q, got_d, so_q, so_d, oen_q, oen_d;
  logic wel_q, wel_d, ppe_q, ppe_d, busy_q, busy_d, commit_q, commit_d;
  logic [1:0] bp_q, bp_d;
  logic [TW-1:0] timer_q, timer_d;
  logic [PAGE_W-1:0] cidx_q, cidx_d;
  logic [PAGE-1:0] mask_q, mask_d;
  logic [DW-1:0] div_q, div_d;
  logic [7:0] byte_in, status;
  logic [ADDR_W-1:0] addr_in;
  logic pb_we, start, prog_tick, f_in_valid, f_in_ready, f_out_valid;
  logic [FW-1:0] f_out_data;

  assign byte_in = {sh_q[6:0], si_s};
  assign addr_in = {sh_q[ADDR_W-2:0], si_s};
  assign hw_prot = ppe_q & ~wp_q[1];
  assign prog_tick = (div_q == '0);

  always_comb begin
    status = 8'h00;
    status[`SPE_ST_PPE] = ppe_q;
    status[`SPE_ST_BPH] = bp_q[1];
    status[`SPE_ST_BPL] = bp_q[0];
    status[`SPE_ST_WEL] = wel_q;
    status[`SPE_ST_BUSY] = busy_q;
  end

  // Upper quarter, upper half or all of the array, by protect code.
  function automatic logic blocked(input logic [1:0] bp, input logic [ADDR_W-1:0] a);
    unique case (bp)
      2'h0: blocked = 1'b0;
      2'h1: blocked = &a[ADDR_W-1:ADDR_W-2];
      2'h2: blocked = a[ADDR_W-1];
      2'h3: blocked = 1'b1;
    endcase
  endfunction

  always_comb begin
    phase_d = phase_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    addr_d = addr_q;
    dout_d = dout_q;
    is_wr_d = is_wr_q;
    got_d = got_q;
    so_d = so_q;
    oen_d = oen_q;
    wel_d = wel_q;
    ppe_d = ppe_q;
    bp_d = bp_q;
    busy_d = busy_q;
    commit_d = commit_q;
    timer_d = timer_q;
    cidx_d = cidx_q;
    mask_d = mask_q;
    pb_we = 1'b0;
    start = 1'b0;
    f_in_valid = 1'b0;
    div_d = prog_tick ? DW'(PROG_DIV - 1) : div_q - 1'b1;
    // The programming engine drains the page while the cycle timer runs.
    if (busy_q) begin
      if (timer_q != '0) begin
        timer_d = timer_q - 1'b1;
      end
      if (commit_q) begin
        f_in_valid = mask_q[cidx_q];
        if (!mask_q[cidx_q] || f_in_ready) begin
          cidx_d = cidx_q + 1'b1;
          if (cidx_q == PAGE_W'(PAGE - 1)) begin
            commit_d = 1'b0;
          end
        end
      end else if (timer_q == '0 && !f_out_valid) begin
        busy_d = 1'b0;
        wel_d = 1'b0;
      end
    end
    if (!cs_low) begin
      phase_d = spe_pkg::P_CMD;
      cnt_d = 4'h0;
      oen_d = 1'b0;
      got_d = 1'b0;
    end
    if (cs_rise) begin
      case (phase_q)
        spe_pkg::P_LSET: wel_d = 1'b1;
        spe_pkg::P_LCLR: wel_d = 1'b0;
        spe_pkg::P_WRITE: begin
          if (got_q && cnt_q == 4'h0) begin
            start = 1'b1;
            wel_d = 1'b0;
          end
        end
        spe_pkg::P_SWRITE: begin
          if (got_q && cnt_q == 4'h0 && !hw_prot) begin
            ppe_d = sh_q[`SPE_ST_PPE];
            bp_d = sh_q[`SPE_ST_BPH:`SPE_ST_BPL];
            start = 1'b1;
            wel_d = 1'b0;
          end
        end
        default: ;
      endcase
    end else if (active && sck_rise) begin
      sh_d = {sh_q[14:0], si_s};
      cnt_d = cnt_q + 1'b1;
      case (phase_q)
        spe_pkg::P_CMD: begin
          if (cnt_q[2:0] == 3'h7) begin
            cnt_d = 4'h0;
            phase_d = spe_pkg::P_IGN;
            unique case (byte_in)
              `SPE_OP_READ: begin
                is_wr_d = 1'b0;
                if (!busy_q) begin
                  phase_d = spe_pkg::P_ADDR;
                end
              end
              `SPE_OP_WRITE: begin
                is_wr_d = 1'b1;
                if (!busy_q && wel_q) begin
                  phase_d = spe_pkg::P_ADDR;
                end
              end
              `SPE_OP_LSET: phase_d = spe_pkg::P_LSET;
              `SPE_OP_LCLR: phase_d = spe_pkg::P_LCLR;
              `SPE_OP_SREAD: begin
                phase_d = spe_pkg::P_SREAD;
                dout_d = status;
              end
              `SPE_OP_SWRITE: begin
                if (!busy_q && wel_q) begin
                  phase_d = spe_pkg::P_SWRITE;
                end
              end
              default: ;
            endcase
          end
        end
        spe_pkg::P_ADDR: begin
          if (cnt_q == `SPE_ADDR_LAST) begin
            cnt_d = 4'h0;
            addr_d = addr_in;
            if (!is_wr_q) begin
              phase_d = spe_pkg::P_READ;
              dout_d = mem[addr_in];
            end else if (blocked(bp_q, addr_in)) begin
              phase_d = spe_pkg::P_IGN;
            end else begin
              phase_d = spe_pkg::P_WRITE;
              mask_d = '0;
            end
          end
        end
        spe_pkg::P_READ: begin
          if (cnt_q[2:0] == 3'h7) begin
            cnt_d = 4'h0;
            addr_d = addr_q + 1'b1;
            dout_d = mem[addr_d];
          end
        end
        spe_pkg::P_SREAD: begin
          if (cnt_q[2:0] == 3'h7) begin
            cnt_d = 4'h0;
            dout_d = status;
          end
        end
        spe_pkg::P_WRITE: begin
          if (cnt_q[2:0] == 3'h7) begin
            cnt_d = 4'h0;
            got_d = 1'b1;
            pb_we = 1'b1;
            mask_d[addr_q[PAGE_W-1:0]] = 1'b1;
            // Bytes past the page end land back at its start.
            addr_d[PAGE_W-1:0] = addr_q[PAGE_W-1:0] + 1'b1;
          end
        end
        spe_pkg::P_SWRITE: begin
          if (cnt_q[2:0] == 3'h7) begin
            cnt_d = 4'h0;
            got_d = 1'b1;
            if (got_q) begin
              phase_d = spe_pkg::P_IGN;
            end
          end
        end
        spe_pkg::P_LSET, spe_pkg::P_LCLR: phase_d = spe_pkg::P_IGN;
        default: cnt_d = cnt_q;
      endcase
    end else if (active && sck_fall) begin
      if (phase_q == spe_pkg::P_READ || phase_q == spe_pkg::P_SREAD) begin
        so_d = dout_q[~cnt_q[2:0]];
        oen_d = 1'b1;
      end
    end
    if (start) begin
      busy_d = 1'b1;
      timer_d = TW'(WR_CYCLES - 1);
      commit_d = (phase_q == spe_pkg::P_WRITE);
      cidx_d = '0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_q <= spe_pkg::P_CMD;
      cnt_q <= 4'h0;
      sh_q <= 16'h0000;
      addr_q <= '0;
      dout_q <= 8'h00;
      is_wr_q <= 1'b0;
      got_q <= 1'b0;
      so_q <= 1'b0;
      oen_q <= 1'b0;
      wel_q <= 1'b0;
      ppe_q <= 1'(`SPE_ST_RESET >> `SPE_ST_PPE);
      bp_q <= 2'h0;
      busy_q <= 1'b0;
      commit_q <= 1'b0;
      timer_q <= '0;
      cidx_q <= '0;
      mask_q <= '0;
      div_q <= '0;
    end else begin
      phase_q <= phase_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      addr_q <= addr_d;
      dout_q <= dout_d;
      is_wr_q <= is_wr_d;
      got_q <= got_d;
      so_q <= so_d;
      oen_q <= oen_d;
      wel_q <= wel_d;
      ppe_q <= ppe_d;
      bp_q <= bp_d;
      busy_q <= busy_d;
      commit_q <= commit_d;
      timer_q <= timer_d;
      cidx_q <= cidx_d;
      mask_q <= mask_d;
      div_q <= div_d;
    end
  end

  // Staging through a small FIFO lets the array accept one byte per program tick.
  spe_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data({cidx_q, pbuf[cidx_q]}),
    .out_valid(f_out_valid),
    .out_ready(prog_tick),
    .out_data(f_out_data)
  );

  always_ff @(posedge clk) begin
    if (pb_we) begin
      pbuf[addr_q[PAGE_W-1:0]] <= byte_in;
    end
    if (f_out_valid && prog_tick) begin
      mem[{addr_q[ADDR_W-1:PAGE_W], f_out_data[FW-1:8]}] <= f_out_data[7:0];
    end
  end

  assign so = so_q;
  assign so_oe_n = ~(active & oen_q &
    (phase_q == spe_pkg::P_READ || phase_q == spe_pkg::P_SREAD));

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  property p_wel_set;
    cs_rise && phase_q == spe_pkg::P_LSET |=> wel_q;
  endproperty
  a_wel_set: assert property (p_wel_set) else $error("latch not set");

  property p_wel_clr;
    cs_rise && phase_q == spe_pkg::P_LCLR |=> !wel_q;
  endproperty
  a_wel_clr: assert property (p_wel_clr) else $error("latch not cleared");

  property p_end_clears;
    $fell(busy_q) |-> !wel_q || $past(cs_rise && phase_q == spe_pkg::P_LSET);
  endproperty
  a_end_clears: assert property (p_end_clears) else $error("latch after write");

  property p_busy_hold;
    start |=> busy_q [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy too short");

  property p_refuse;
    busy_q && active && sck_rise && phase_q == spe_pkg::P_CMD && cnt_q == 4'h7 &&
      byte_in == `SPE_OP_READ |=> phase_q == spe_pkg::P_IGN;
  endproperty
  a_refuse: assert property (p_refuse) else $error("read during busy");

  property p_wrap;
    active && sck_rise && phase_q == spe_pkg::P_READ && cnt_q == 4'h7 && (&addr_q)
      |=> addr_q == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no rollover");

  property p_hold_hiz;
    !hold_q[1] |-> so_oe_n ##1 ($past(!cs_low) || $stable(cnt_q) && $stable(sh_q));
  endproperty
  a_hold_hiz: assert property (p_hold_hiz) else $error("driving in hold");

  property p_unknown;
    phase_q == spe_pkg::P_IGN |-> so_oe_n && $stable(wel_q) || $fell(busy_q);
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown opcode acted");

  property p_wp_block;
    cs_rise && phase_q == spe_pkg::P_SWRITE && hw_prot |-> !start ##1 $stable(bp_q) &&
      $stable(ppe_q);
  endproperty
  a_wp_block: assert property (p_wp_block) else $error("status write leaked");

  property p_protect;
    active && sck_rise && phase_q == spe_pkg::P_ADDR && cnt_q == `SPE_ADDR_LAST &&
      is_wr_q && bp_q == 2'h3 |=> phase_q == spe_pkg::P_IGN;
  endproperty
  a_protect: assert property (p_protect) else $error("protected write");

  property p_no_partial;
    cs_rise && phase_q == spe_pkg::P_WRITE && cnt_q != 4'h0 |=> !busy_q || $past(busy_q);
  endproperty
  a_no_partial: assert property (p_no_partial) else $error("partial write");
endmodule

// *** bench/spe_host.sv ***
// Host model: the bus master that drives the serial link of the EEPROM block.
// Assumes the block clock; every pin change lands on a falling edge of clk.
`timescale 1ns/1ps
module spe_host (
  // Clock.
  input wire logic clk,
  // Link to the device.
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n,
  input wire logic so_pin,
  input wire logic so_oe_n
);
  logic oe_seen;
  logic oe_in_hold;

  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
    oe_seen = 1'b0;
    oe_in_hold = 1'b0;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // The sync stages need select low a few cycles before the first clock edge.
  task automatic open_frame();
    @(negedge clk);
    cs_n = 1'b0;
    oe_seen = 1'b0;
    idle(4);
  endtask

  // The clock stands low between frames; a released data line does not keep its value.
  task automatic close_frame();
    @(negedge clk);
    cs_n = 1'b1;
    si = ~si;
    idle(6);
  endtask

  // Hold moves only while sck is low; the pulses and data flips inside must be ignored.
  task automatic hold_pause();
    logic s;
    s = si;
    // The clock fall just before must be seen by the device before the pause begins.
    idle(4);
    hold_n = 1'b0;
    idle(4);
    oe_in_hold = so_oe_n;
    repeat (2) begin
      sck = 1'b1;
      si = ~si;
      idle(4);
      sck = 1'b0;
      idle(4);
    end
    si = s;
    hold_n = 1'b1;
    idle(4);
  endtask

  // Shifts the top n bits of tx; so is taken late in the high phase, well after the fall.
  task automatic shift(input int n, input logic [7:0] tx, input logic pause,
                       output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      si = tx[i];
      if (pause && i == 4)
        hold_pause();
      idle(4);
      sck = 1'b1;
      idle(4);
      rx = {rx[6:0], so_pin};
      oe_seen = oe_seen | ~so_oe_n;
      sck = 1'b0;
    end
  endtask
endmodule

// *** bench/spe_eeprom_bench.sv ***
// Self-checking bench of the serial EEPROM command block.
// Assumes the host model drives the link and a shadow memory predicts reads.
`timescale 1ns/1ps
`include "spe_consts.svh"
module spe_eeprom_bench;
  // A short write cycle keeps the run small; it still exceeds a full page program.
  localparam int WRC = 600;
  logic clk, nrst, wp_n, cs_n, sck, si, hold_n, so, so_oe_n;
  wire so_pin;
  int n_fail, n_tests, seed;
  logic [7:0] junk, st;
  logic [15:0] a;
  logic [1:0] bp_exp;
  logic [7:0] mem [int];
  logic [15:0] pa [4] = '{16'h3fff, 16'h4000, 16'h5fff, 16'h6000};

  assign so_pin = so_oe_n ? 1'bz : so;

  spe_eeprom #(.WR_CYCLES(WRC)) dut_u (.clk(clk), .nrst(nrst), .cs_n(cs_n), .sck(sck),
    .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n));
  spe_host host_u (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
    .so_pin(so_pin), .so_oe_n(so_oe_n));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic prot(input logic [1:0] bp, input logic [14:0] ad);
    case (bp)
      2'b00: return 1'b0;
      2'b01: return ad >= 15'h6000;
      2'b10: return ad >= 15'h4000;
      default: return 1'b1;
    endcase
  endfunction

  task automatic cmd(input logic [7:0] op);
    host_u.open_frame();
    host_u.shift(8, op, 1'b0, junk);
    host_u.close_frame();
  endtask

  task automatic frame_hdr(input logic [7:0] op, input logic [15:0] ad);
    host_u.open_frame();
    host_u.shift(8, op, 1'b0, junk);
    host_u.shift(8, ad[15:8], 1'b0, junk);
    host_u.shift(8, ad[7:0], 1'b0, junk);
  endtask

  task automatic rd_status(output logic [7:0] s);
    host_u.open_frame();
    host_u.shift(8, `SPE_OP_SREAD, 1'b0, junk);
    host_u.shift(8, 8'h00, 1'b0, s);
    host_u.close_frame();
  endtask

  task automatic st_is(input logic [7:0] exp);
    logic [7:0] s;
    rd_status(s);
    check("status", s, exp);
  endtask

  // Busy polling is bounded; running out of polls ends the run.
  task automatic wait_idle();
    logic [7:0] s;
    for (int i = 0; i < 40; i++) begin
      rd_status(s);
      if (s[0] === 1'b0)
        return;
    end
    n_fail++;
    $display("unexpected busy: expected 0 seen 1");
    end_sim();
  endtask

  task automatic sw(input logic [7:0] v);
    cmd(`SPE_OP_LSET);
    host_u.open_frame();
    host_u.shift(8, `SPE_OP_SWRITE, 1'b0, junk);
    host_u.shift(8, v, 1'b0, junk);
    host_u.close_frame();
    wait_idle();
  endtask

  task automatic wr(input logic [15:0] ad, input int n, input int extra, input logic p);
    logic [7:0] d;
    logic land;
    land = (extra == 0) && !prot(bp_exp, ad[14:0]);
    cmd(`SPE_OP_LSET);
    frame_hdr(`SPE_OP_WRITE, ad);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      host_u.shift(8, d, p && i == 1, junk);
      if (land)
        mem[{ad[14:6], 6'(ad[5:0] + i)}] = d;
    end
    if (extra > 0)
      host_u.shift(extra, 8'h00, 1'b0, junk);
    host_u.close_frame();
  endtask

  task automatic rd(input logic [15:0] ad, input int n, input logic p);
    logic [7:0] b;
    frame_hdr(`SPE_OP_READ, ad);
    for (int i = 0; i < n; i++) begin
      host_u.shift(8, 8'h00, p && i == 1, b);
      check("read data", b, mem[(int'(ad) + i) & 32'h7fff]);
    end
    host_u.close_frame();
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    $display("unexpected run length: expected end seen timeout");
    end_sim();
  end

  initial begin
    seed = 32'h6ce4;
    n_fail = 0;
    n_tests = 0;
    nrst = 1'b0;
    wp_n = 1'b1;
    bp_exp = 2'b00;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    st_is(8'h00);
    $display("test reset done");
    cmd(`SPE_OP_LSET);
    st_is(8'h02);
    cmd(`SPE_OP_LCLR);
    st_is(8'h00);
    host_u.open_frame();
    host_u.shift(8, `SPE_OP_LSET, 1'b0, junk);
    host_u.shift(1, 8'h00, 1'b0, junk);
    host_u.close_frame();
    st_is(8'h00);
    $display("test latch done");
    a = 16'(({$random(seed)} % 200) * 64 + 60);
    wr(a, 8, 0, 1'b1);
    rd_status(st);
    check("busy and latch", st & 8'h03, 8'h01);
    frame_hdr(`SPE_OP_READ, a);
    host_u.shift(8, 8'h00, 1'b0, junk);
    check("output during write", {7'h0, host_u.oe_seen}, 8'h00);
    host_u.close_frame();
    wait_idle();
    st_is(8'h00);
    rd(a, 4, 1'b1);
    check("output in hold", {7'h0, host_u.oe_in_hold}, 8'h01);
    rd(a & 16'hffc0, 4, 1'b0);
    $display("test page write done");
    wr(16'h7fff, 1, 0, 1'b0);
    wait_idle();
    wr(16'h0000, 1, 0, 1'b0);
    wait_idle();
    rd(16'hffff, 2, 1'b0);
    wr(16'h0100, 2, 3, 1'b0);
    rd_status(st);
    check("busy after cut write", st & 8'h01, 8'h00);
    cmd(`SPE_OP_LCLR);
    $display("test wrap and cut done");
    for (int p = 0; p < 4; p++) begin
      sw(8'(p << 2));
      bp_exp = 2'(p);
      st_is(8'(p << 2));
      foreach (pa[k]) begin
        wr(pa[k], 1, 0, 1'b0);
        wait_idle();
        rd(pa[k], 1, 1'b0);
      end
    end
    $display("test block protect done");
    sw(8'h80);
    bp_exp = 2'b00;
    st_is(8'h80);
    wp_n = 1'b0;
    sw(8'h8c);
    st_is(8'h82);
    cmd(`SPE_OP_LCLR);
    st_is(8'h80);
    wp_n = 1'b1;
    sw(8'h00);
    st_is(8'h00);
    $display("test pin protect done");
    host_u.open_frame();
    host_u.shift(8, 8'hff, 1'b0, junk);
    host_u.shift(8, 8'h00, 1'b0, junk);
    check("output after unknown", {7'h0, host_u.oe_seen}, 8'h00);
    host_u.close_frame();
    st_is(8'h00);
    $display("test unknown opcode done");
    end_sim();
  end
endmodule
